// >>> rtl/bcre_engine.sv
`timescale 1ns/10ps
module bcre_engine import bcre_pkg::*; #(
	parameter int unsigned SAMPLE_CYCLES  = bcre_pkg::SAMPLE_CYC,
	parameter int unsigned RESTART_CYCLES = bcre_pkg::RESTART_CYC
) (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  reset_n,
	// Monitor point access to the command register
	input  wire bcre_pkg::bcre_mp_req_type  mp_req,
	output logic [7:0]                 cmd_code,
	// Working memory access
	input  wire bcre_pkg::bcre_par_req_type par_req,
	output logic [11:0]                par_rdata,
	// Receiver power readings and program code
	input  wire logic [2:0][11:0]      rx_power,
	input  wire logic [13:0]           code_data,
	output logic [10:0]                code_addr,
	// Board controls
	output logic                       psu_en,
	output logic                       fault_line,
	output logic                       dac_load,
	output logic [2:0][11:0]           dac_data,
	output logic [15:0]                crc_value,
	output logic [7:0]                 led_out,
	output logic [7:0]                 status_word
);
	import bcre_pkg::*;

	bcre_regs_type r;
	bcre_regs_type next_r;

	// Simple additive checksum over the parameter block
	function automatic logic [11:0] sum_words(input logic [NPARAM-1:0][11:0] w);
		logic [11:0] s;
		s = 12'h000;
		for (int i = 0; i < NPARAM; i++) begin
			s = s + w[i];
		end
		return s;
	endfunction : sum_words

	// One sixteen-bit word through the code CRC, MSB first
	function automatic logic [15:0] crc_step(input logic [15:0] c_in, input logic [15:0] d);
		logic [15:0] c;
		logic        fb;
		c = c_in;
		for (int i = 15; i >= 0; i--) begin
			fb = c[15] ^ d[i];
			c = {c[14:0], 1'b0};
			if (fb) begin
				c = c ^ CRC_POLY;
			end
		end
		return c;
	endfunction : crc_step

	// Known single-step or multi-step command code
	function automatic logic is_known(input logic [7:0] code);
		return (code >= CMD_NV_UPDATE && code <= CMD_LED_OFF) ||
			(code >= CMD_CAL_FIRST && code <= CMD_CAL_LAST);
	endfunction : is_known

	// Next-state logic for the whole engine
	always_comb begin
		logic [2:0]  cal_idx;
		logic [1:0]  rx;
		logic        full;
		logic [19:0] acc_n;
		logic [11:0] avg;
		logic [11:0] lo;
		logic [11:0] hi;
		cal_idx = 3'(r.cmd - (CMD_CAL_FIRST + CAL_STEP));
		full = (cal_idx >= 3'd3);
		rx = full ? 2'(cal_idx - 3'd3) : cal_idx[1:0];
		acc_n = r.acc + 20'(rx_power[rx]);
		avg = acc_n[19:8];
		lo = full ? FULL_MIN : ZERO_MIN;
		hi = full ? FULL_MAX : ZERO_MAX;
		next_r = r;
		next_r.dac_load = 1'b0;

		// Host edits only ever land in working memory
		if (par_req.wr && par_req.idx < 4'(NPARAM)) begin
			next_r.work[par_req.idx] = par_req.data;
		end
		next_r.par_rdata = (par_req.idx < 4'(NPARAM)) ? r.work[par_req.idx] : 12'h000;
		next_r.led_out = r.led_en ? {6'h00, ~r.psu_en, r.fault} : 8'h00;
		next_r.status = 8'h00;
		next_r.status[STAT_FAULT_BIT] = r.fault;
		next_r.status[STAT_PSU_BIT] = ~r.psu_en;
		next_r.status[STAT_SUM_BIT] = r.sum_bad;

		unique case (r.state)
			ST_IDLE: begin
				// Writes during a running command are ignored so progress stays honest
				if (mp_req.wr && mp_req.addr == CMD_ADDR) begin
					if (mp_req.data[7]) begin
						next_r.cmd = FAIL_CODE;
					end else begin
						next_r.cmd = mp_req.data;
						if (mp_req.data != CMD_IDLE) begin
							next_r.state = ST_DISPATCH;
						end
					end
				end
			end
			ST_DISPATCH: begin
				next_r.state = ST_IDLE;
				next_r.cmd = CMD_IDLE;
				case (r.cmd)
					CMD_NV_UPDATE: begin
						next_r.nv = r.work;
						next_r.nv_sum = sum_words(r.work);
					end
					CMD_NV_RELOAD: begin
						next_r.work = r.nv;
						if (sum_words(r.nv) != r.nv_sum) begin
							next_r.sum_bad = 1'b1;
						end
					end
					CMD_PSU_OFF: begin
						next_r.psu_en = 1'b0;
					end
					CMD_PSU_ON: begin
						// Register stays at the code until the supplies have settled
						next_r.psu_en = 1'b1;
						next_r.cmd = r.cmd;
						next_r.wait_cnt = 32'h0000_0000;
						next_r.state = ST_RESTART;
					end
					CMD_FAULT_ON: begin
						next_r.fault = 1'b1;
					end
					CMD_FAULT_OFF: begin
						next_r.fault = 1'b0;
					end
					CMD_FINE_LOAD: begin
						next_r.dac_data = r.work[FINE_BASE+2:FINE_BASE];
						next_r.dac_load = 1'b1;
					end
					CMD_CRC: begin
						next_r.cmd = r.cmd;
						next_r.crc_work = CRC_INIT;
						next_r.code_addr = 11'h000;
						next_r.state = ST_CRC;
					end
					CMD_LED_ON: begin
						next_r.led_en = 1'b1;
					end
					CMD_LED_OFF: begin
						next_r.led_en = 1'b0;
					end
					default: begin
						if (r.cmd >= CMD_CAL_FIRST && r.cmd <= CMD_CAL_LAST) begin
							next_r.cmd = r.cmd + CAL_STEP;
							next_r.acc = 20'h00000;
							next_r.smp = 8'h00;
							next_r.tick = 32'h0000_0000;
							next_r.state = ST_CAL;
						end else begin
							next_r.cmd = FAIL_CODE;
						end
					end
				endcase
			end
			ST_CAL: begin
				// One reading per sample period; 256 periods make the whole run
				next_r.tick = r.tick + 32'h0000_0001;
				if (r.tick == 32'(SAMPLE_CYCLES - 1)) begin
					next_r.tick = 32'h0000_0000;
					next_r.acc = acc_n;
					next_r.smp = r.smp + 8'h01;
					if (r.smp == CAL_LAST_SMP) begin
						next_r.state = ST_IDLE;
						if (avg < lo) begin
							next_r.cmd = FAIL_LOW;
						end else if (avg > hi) begin
							next_r.cmd = FAIL_HIGH;
						end else begin
							if (full) begin
								next_r.work[N1_BASE + int'(rx)] = avg;
							end else begin
								next_r.work[N0_BASE + int'(rx)] = avg;
							end
							next_r.cmd = CMD_IDLE;
						end
					end
				end
			end
			ST_RESTART: begin
				next_r.wait_cnt = r.wait_cnt + 32'h0000_0001;
				if (r.wait_cnt == 32'(RESTART_CYCLES - 1)) begin
					next_r.cmd = CMD_IDLE;
					next_r.state = ST_IDLE;
				end
			end
			ST_CRC: begin
				// Code words are fourteen bits, zero-extended before the CRC
				next_r.crc_work = crc_step(r.crc_work, {2'b00, code_data});
				next_r.code_addr = r.code_addr + 11'h001;
				if (r.code_addr == CRC_LAST_ADDR) begin
					next_r.crc = crc_step(r.crc_work, {2'b00, code_data});
					next_r.code_addr = 11'h000;
					next_r.cmd = CMD_IDLE;
					next_r.state = ST_IDLE;
				end
			end
			default: begin
				next_r.state = ST_IDLE;
				next_r.cmd = FAIL_CODE;
			end
		endcase
	end

	// State register; supplies start off, LEDs start enabled
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
			r.state <= ST_IDLE;
			r.psu_en <= PSU_EN_RESET;
			r.led_en <= LED_EN_RESET;
		end else begin
			r <= next_r;
		end
	end

	// Outputs straight from the state record
	assign cmd_code    = r.cmd;
	assign par_rdata   = r.par_rdata;
	assign code_addr   = r.code_addr;
	assign psu_en      = r.psu_en;
	assign fault_line  = r.fault;
	assign dac_load    = r.dac_load;
	assign dac_data    = r.dac_data;
	assign crc_value   = r.crc;
	assign led_out     = r.led_out;
	assign status_word = r.status;

	// Checks on the command engine
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_busy_positive: assert property (
		(r.state != ST_IDLE) |-> (!r.cmd[7] && r.cmd != CMD_IDLE))
		else $error("command register not positive while busy");

	a_cal_marked: assert property (
		(r.state == ST_DISPATCH && r.cmd >= CMD_CAL_FIRST && r.cmd <= CMD_CAL_LAST)
		|=> (r.state == ST_CAL && r.cmd == $past(r.cmd) + CAL_STEP))
		else $error("calibration code not raised by eight");

	a_cal_result: assert property (
		(r.state == ST_CAL) ##1 (r.state == ST_IDLE)
		|-> (r.cmd == CMD_IDLE || r.cmd == FAIL_LOW || r.cmd == FAIL_HIGH))
		else $error("calibration ended with an unexpected value");

	a_update_sum: assert property (
		(r.state == ST_DISPATCH && r.cmd == CMD_NV_UPDATE)
		|=> (r.nv == $past(r.work) && r.nv_sum == sum_words(r.nv) && r.cmd == CMD_IDLE))
		else $error("update did not store block and checksum");

	a_reload_flag: assert property (
		(r.state == ST_DISPATCH && r.cmd == CMD_NV_RELOAD && sum_words(r.nv) != r.nv_sum)
		|=> ##1 status_word[STAT_SUM_BIT])
		else $error("checksum mismatch not flagged");

	a_restart_on: assert property (
		(r.state == ST_DISPATCH && r.cmd == CMD_PSU_ON)
		|=> (psu_en && r.state == ST_RESTART && cmd_code == CMD_PSU_ON))
		else $error("restart did not switch supplies on");

	a_shut_off: assert property (
		(r.state == ST_DISPATCH && r.cmd == CMD_PSU_OFF) |=> (!psu_en && cmd_code == CMD_IDLE))
		else $error("shut-down did not switch supplies off");

	a_fault_force: assert property (
		(r.state == ST_DISPATCH && (r.cmd == CMD_FAULT_ON || r.cmd == CMD_FAULT_OFF))
		|=> (fault_line == ($past(r.cmd) == CMD_FAULT_ON)))
		else $error("fault line not forced as commanded");

	a_fine_load: assert property (
		(r.state == ST_DISPATCH && r.cmd == CMD_FINE_LOAD)
		|=> (dac_load && dac_data == $past(r.work[FINE_BASE+2:FINE_BASE])))
		else $error("fine-tune values not sent to the DAC");

	a_led_blank: assert property (
		(r.state == ST_DISPATCH && r.cmd == CMD_LED_OFF) |=> ##1 (led_out == 8'h00))
		else $error("LEDs not blanked");

	a_unknown_fail: assert property (
		(r.state == ST_DISPATCH && !is_known(r.cmd)) |=> (cmd_code == FAIL_CODE))
		else $error("unknown command not refused");

	a_fail_holds: assert property (
		(r.state == ST_IDLE && r.cmd[7] && !(mp_req.wr && mp_req.addr == CMD_ADDR))
		|=> (cmd_code == $past(r.cmd)))
		else $error("failure value not left in the command register");

	a_acc_steady: assert property (
		(r.state == ST_CAL && r.tick != 32'(SAMPLE_CYCLES - 1))
		|=> (r.state == ST_CAL && r.acc == $past(r.acc)))
		else $error("calibration sum moved between sample ticks");

	a_restart_hold: assert property (
		(r.state == ST_RESTART && r.wait_cnt != 32'(RESTART_CYCLES - 1))
		|=> (r.state == ST_RESTART && psu_en && cmd_code == CMD_PSU_ON))
		else $error("restart left its wait early");

	a_crc_walk: assert property (
		(r.state == ST_CRC && r.code_addr != CRC_LAST_ADDR)
		|=> (r.state == ST_CRC && code_addr == $past(r.code_addr) + 11'h001))
		else $error("code checksum skipped an address");

	a_led_enable: assert property (
		(r.state == ST_DISPATCH && r.cmd == CMD_LED_ON)
		|=> ##1 (led_out == {6'h00, ~psu_en, fault_line}))
		else $error("LEDs not enabled");

	c_cal_fail: cover property ((r.state == ST_CAL) ##1 (r.state == ST_IDLE && r.cmd[7]));
	c_cal_done: cover property ((r.state == ST_CAL) ##1 (r.state == ST_IDLE));
	c_crc_done: cover property ((r.state == ST_CRC) ##1 (r.state == ST_IDLE));
	c_restart_done: cover property ((r.state == ST_RESTART) ##1 (r.state == ST_IDLE));
	c_sum_bad: cover property ($rose(r.sum_bad));

endmodule : bcre_engine

// >>> rtl/bcre_pkg.sv
package bcre_pkg;

	// Command register location among the monitor points
	localparam logic [7:0]  CMD_ADDR       = 8'h40;

	// Command codes, zero means idle
	localparam logic [7:0]  CMD_IDLE       = 8'h00;
	localparam logic [7:0]  CMD_NV_UPDATE  = 8'h01;
	localparam logic [7:0]  CMD_NV_RELOAD  = 8'h02;
	localparam logic [7:0]  CMD_PSU_OFF    = 8'h03;
	localparam logic [7:0]  CMD_PSU_ON     = 8'h04;
	localparam logic [7:0]  CMD_FAULT_ON   = 8'h05;
	localparam logic [7:0]  CMD_FAULT_OFF  = 8'h06;
	localparam logic [7:0]  CMD_FINE_LOAD  = 8'h07;
	localparam logic [7:0]  CMD_CRC        = 8'h08;
	localparam logic [7:0]  CMD_LED_ON     = 8'h09;
	localparam logic [7:0]  CMD_LED_OFF    = 8'h0a;
	// Calibration: zero point rx0..rx2, then 1 mW point rx0..rx2
	localparam logic [7:0]  CMD_CAL_FIRST  = 8'h10;
	localparam logic [7:0]  CMD_CAL_LAST   = 8'h15;
	localparam logic [7:0]  CAL_STEP       = 8'h08;

	// Failure answers
	localparam logic [7:0]  FAIL_HIGH      = 8'hff;
	localparam logic [7:0]  FAIL_LOW       = 8'hfe;
	localparam logic [7:0]  FAIL_CODE      = 8'hfd;

	// Timing
	localparam int unsigned CLK_KHZ        = 50000;
	localparam int unsigned SAMPLE_MS      = 10;
	localparam int unsigned SAMPLE_CYC     = SAMPLE_MS * CLK_KHZ;
	localparam int unsigned RESTART_MS     = 100;
	localparam int unsigned RESTART_CYC    = RESTART_MS * CLK_KHZ;
	localparam logic [7:0]  CAL_LAST_SMP   = 8'hff;

	// Code checksum
	localparam logic [10:0] CRC_LAST_ADDR  = 11'h7ff;
	localparam logic [15:0] CRC_INIT       = 16'hffff;
	localparam logic [15:0] CRC_POLY       = 16'h1021;

	// Primary status word bits
	localparam int          STAT_FAULT_BIT = 7;
	localparam int          STAT_PSU_BIT   = 6;
	localparam int          STAT_SUM_BIT   = 4;

	// Working memory layout, twelve-bit words
	localparam int          NPARAM         = 9;
	localparam int          N0_BASE        = 0;
	localparam int          N1_BASE        = 3;
	localparam int          FINE_BASE      = 6;

	// Plausible calibration averages
	localparam logic [11:0] ZERO_MIN       = 12'h000;
	localparam logic [11:0] ZERO_MAX       = 12'h0ff;
	localparam logic [11:0] FULL_MIN       = 12'h400;
	localparam logic [11:0] FULL_MAX       = 12'hffe;

	// Reset values
	localparam logic        LED_EN_RESET   = 1'b1;
	localparam logic        PSU_EN_RESET   = 1'b0;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_DISPATCH = 3'b001,
		ST_CAL      = 3'b010,
		ST_RESTART  = 3'b011,
		ST_CRC      = 3'b100
	} bcre_state_type;

	typedef struct packed {
		logic        wr;
		logic [7:0]  addr;
		logic [7:0]  data;
	} bcre_mp_req_type;

	typedef struct packed {
		logic        wr;
		logic [3:0]  idx;
		logic [11:0] data;
	} bcre_par_req_type;

	typedef struct packed {
		bcre_state_type          state;
		logic [7:0]              cmd;
		logic [NPARAM-1:0][11:0] work;
		logic [NPARAM-1:0][11:0] nv;
		logic [11:0]             nv_sum;
		logic                    sum_bad;
		logic                    psu_en;
		logic                    fault;
		logic                    led_en;
		logic [19:0]             acc;
		logic [7:0]              smp;
		logic [31:0]             tick;
		logic [31:0]             wait_cnt;
		logic [15:0]             crc;
		logic [15:0]             crc_work;
		logic [10:0]             code_addr;
		logic                    dac_load;
		logic [2:0][11:0]        dac_data;
		logic [11:0]             par_rdata;
		logic [7:0]              led_out;
		logic [7:0]              status;
	} bcre_regs_type;

endpackage : bcre_pkg

// >>> bench/bcre_bridge.sv
`timescale 1ns/10ps
// Far-side monitor point master: turns a one-cycle go into a command write
module bcre_bridge import bcre_pkg::*; (
	// Request from the control side
	input  wire logic                 go,
	input  wire logic [7:0]           code,
	// Monitor point bus
	output bcre_pkg::bcre_mp_req_type mp_req
);
	// Idle data is inverted so a stale byte never passes for the last command
	assign mp_req = '{wr: go, addr: CMD_ADDR, data: go ? code : ~code};
endmodule : bcre_bridge

// >>> bench/board_command_register_engine_test.sv
`timescale 1ns/10ps
module board_command_register_engine_test;
	import bcre_pkg::*;
	// Short counts keep a calibration near a thousand cycles
	localparam int SMP = 4;
	localparam int RST = 8;
	typedef struct packed {
		logic [7:0] c;
		logic [7:0] res;
		logic       psu;
		logic       flt;
		logic [7:0] led;
	} bcre_row_type;
	typedef struct packed {
		logic [7:0]  c;
		logic [11:0] pwr;
		logic [7:0]  res;
		logic [3:0]  idx;
	} bcre_cal_type;
	// Connections and bench state
	logic             clk = 1'b0;
	logic             reset_n = 1'b0;
	logic             go = 1'b0;
	logic [7:0]       code = 8'h00;
	bcre_mp_req_type  mp_req;
	bcre_par_req_type par_req = '0;
	logic [2:0][11:0] rx_power = '0;
	logic [13:0]      code_data;
	logic [10:0]      code_addr;
	logic [7:0]       cmd_code, led_out, status_word;
	logic [11:0]      par_rdata;
	logic             psu_en, fault_line, dac_load;
	logic [2:0][11:0] dac_data;
	logic [15:0]      crc_value;
	int               err_count = 0;
	int               compares = 0;
	int               n;
	int               rx;
	bcre_row_type rows[8] = '{
		'{CMD_PSU_OFF, 8'h00, 1'b0, 1'b0, 8'h02}, '{CMD_FAULT_ON, 8'h00, 1'b0, 1'b1, 8'h03},
		'{CMD_LED_OFF, 8'h00, 1'b0, 1'b1, 8'h00}, '{CMD_LED_ON, 8'h00, 1'b0, 1'b1, 8'h03},
		'{CMD_FAULT_OFF, 8'h00, 1'b0, 1'b0, 8'h02}, '{CMD_PSU_ON, 8'h00, 1'b1, 1'b0, 8'h00},
		'{8'h3f, FAIL_CODE, 1'b1, 1'b0, 8'h00}, '{8'h80, FAIL_CODE, 1'b1, 1'b0, 8'h00}};
	bcre_cal_type cals[6] = '{
		'{8'h10, 12'h080, 8'h00, 4'h0}, '{8'h11, 12'h300, FAIL_HIGH, 4'h1},
		'{8'h12, 12'h0ff, 8'h00, 4'h2}, '{8'h13, 12'h3ff, FAIL_LOW, 4'h3},
		'{8'h14, 12'h800, 8'h00, 4'h4}, '{8'h15, 12'hffe, 8'h00, 4'h5}};

	// 50 MHz clock
	always #10 clk = ~clk;
	// Program code pattern: each word holds its own address
	assign code_data = {3'b000, code_addr};

	bcre_bridge BRIDGE (.go(go), .code(code), .mp_req(mp_req));
	bcre_engine #(.SAMPLE_CYCLES(SMP), .RESTART_CYCLES(RST)) DUT (
		.clk(clk), .reset_n(reset_n), .mp_req(mp_req), .cmd_code(cmd_code),
		.par_req(par_req), .par_rdata(par_rdata), .rx_power(rx_power),
		.code_data(code_data), .code_addr(code_addr), .psu_en(psu_en),
		.fault_line(fault_line), .dac_load(dac_load), .dac_data(dac_data),
		.crc_value(crc_value), .led_out(led_out), .status_word(status_word));

	task automatic check(input logic [39:0] got, input logic [39:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	task automatic pulse(input logic [7:0] c);
		@(negedge clk);
		go = 1'b1;
		code = c;
		@(negedge clk);
		go = 1'b0;
	endtask : pulse

	// Bounded poll: busy means positive and nonzero
	task automatic wait_done(output int cyc);
		cyc = 0;
		while (cmd_code !== 8'h00 && cmd_code[7] !== 1'b1 && cyc < 5000) begin
			@(negedge clk);
			cyc++;
		end
		// A command that never settles is a mismatch, not a silent pass
		if (cyc >= 5000) begin
			err_count++;
			$display("[FAIL] %0t command did not finish", $time);
		end
	endtask : wait_done

	task automatic par(input logic wr, input logic [3:0] idx, input logic [11:0] d);
		@(negedge clk);
		par_req = '{wr: wr, idx: idx, data: d};
		@(negedge clk);
		par_req.wr = 1'b0;
	endtask : par

	// Bitwise reference, slow but independent of any table
	function automatic logic [15:0] crc_ref();
		logic [15:0] c;
		logic [15:0] w;
		c = CRC_INIT;
		for (int a = 0; a < 2048; a++) begin
			w = 16'(a);
			for (int b = 15; b >= 0; b--) begin
				c = {c[14:0], 1'b0} ^ ((c[15] ^ w[b]) ? CRC_POLY : 16'h0000);
			end
		end
		return c;
	endfunction : crc_ref

	task automatic summarize();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : summarize

	// Watchdog sized well above the roughly eight thousand cycles of the run
	initial begin
		#(20 * 40000);
		err_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		summarize();
	end

	// Main sequence
	initial begin
		repeat (3) @(negedge clk);
		reset_n = 1'b1;
		foreach (rows[i]) begin
			pulse(rows[i].c);
			check(cmd_code, rows[i].c[7] ? FAIL_CODE : rows[i].c, "accept");
			wait_done(n);
			repeat (2) @(negedge clk);
			check(cmd_code, rows[i].res, "result");
			check({psu_en, fault_line}, {rows[i].psu, rows[i].flt}, "controls");
			check(led_out, rows[i].led, "leds");
			check(status_word, {rows[i].flt, ~rows[i].psu, 6'h00}, "status");
			check(n >= RST || rows[i].c != CMD_PSU_ON, 1'b1, "restart time");
		end
		$display("test command table done");
		foreach (cals[i]) begin
			rx = int'((cals[i].c - CMD_CAL_FIRST) % 3);
			rx_power = {3{~cals[i].pwr}};
			rx_power[rx] = cals[i].pwr;
			pulse(cals[i].c);
			@(negedge clk);
			check(cmd_code, cals[i].c + CAL_STEP, "cal busy");
			if (i == 0) begin
				pulse(CMD_LED_OFF);
				check(cmd_code, cals[i].c + CAL_STEP, "busy refuse");
			end
			wait_done(n);
			check(n > 250 * SMP && n < 260 * SMP, 1'b1, "cal time");
			check(cmd_code, cals[i].res, "cal result");
			if (cals[i].res == 8'h00) begin
				par(1'b0, cals[i].idx, 12'h000);
				check(par_rdata, cals[i].pwr, "cal store");
			end
		end
		$display("test calibration done");
		for (int k = 0; k < 3; k++) par(1'b1, 4'(FINE_BASE + k), 12'(12'h123 * (k + 1)));
		pulse(CMD_FINE_LOAD);
		n = 0;
		while (dac_load !== 1'b1 && n < 8) begin
			@(negedge clk);
			n++;
		end
		check({dac_load, dac_data}, {1'b1, 12'h369, 12'h246, 12'h123}, "dac");
		$display("test fine tune done");
		par(1'b1, 4'h0, 12'h011);
		pulse(CMD_NV_UPDATE);
		wait_done(n);
		par(1'b1, 4'h0, 12'h0aa);
		par(1'b0, 4'h0, 12'h000);
		check(par_rdata, 12'h0aa, "work edit");
		pulse(CMD_NV_RELOAD);
		wait_done(n);
		repeat (2) @(negedge clk);
		par(1'b0, 4'h0, 12'h000);
		check(par_rdata, 12'h011, "reload");
		check(status_word[STAT_SUM_BIT], 1'b0, "sum good");
		$display("test storage done");
		pulse(CMD_CRC);
		wait_done(n);
		check(crc_value, crc_ref(), "crc");
		$display("test crc done");
		// Blank the LEDs, then reset in mid-calibration: they must come back on
		pulse(CMD_LED_OFF);
		wait_done(n);
		pulse(CMD_CAL_FIRST);
		repeat (5) @(negedge clk);
		reset_n = 1'b0;
		@(negedge clk);
		check({cmd_code, led_out, psu_en}, 17'h0, "in reset");
		reset_n = 1'b1;
		repeat (2) @(negedge clk);
		check({led_out, status_word}, 16'h0240, "after reset");
		$display("test mid-run reset done");
		summarize();
	end
endmodule : board_command_register_engine_test
